// file: rtl/ssr_defines.svh
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
// frame layout
`define SSR_WORD_W 16
`define SSR_ADDR_HI 15
`define SSR_ADDR_LO 12
`define SSR_CNT_W 5
`define SSR_FRAME_BITS 5'h10
// status word addresses
`define SSR_A_QUICK 4'h1
`define SSR_A_CH1 4'h2
`define SSR_A_CH4 4'h5
`define SSR_A_DEV 4'h7
`define SSR_A_IO 4'h8
`define SSR_A_ID 4'h9
// prescaler divider codes
`define SSR_PRS_DIV4 2'h0
`define SSR_PRS_DIV2 2'h1
// duty range limits per divider
`define SSR_DC_MIN4 8'h03
`define SSR_DC_MAX4 8'hfb
`define SSR_DC_MIN21 8'h07
`define SSR_DC_MAX21 8'hf7
// minimum on/off time, microseconds
`define SSR_TMIN_SLOW_US 156
`define SSR_TMIN_FAST_US 78
`define SSR_CLK_MHZ 100
`endif

// file: rtl/ssr_pkg.sv
package ssr_pkg;
  // per-channel fault indications
  typedef struct packed {
    logic overcurrent;
    logic overtemp_warning;
    logic overtemp_shutdown;
    logic open_load_on_state;
    logic open_load_off_state;
  } ssr_chan_s;
  // device-level flags
  typedef struct packed {
    logic registers_cleared_flag;
    logic under_voltage_flag;
    logic over_voltage_flag;
    logic charge_pump_fault;
    logic pwm_clock_fail;
    logic test_mode_active;
    logic serial_link_fail;
    logic fail_mode_flag;
  } ssr_dev_s;
  // link-side frame state
  typedef enum logic [0:0] {SSR_IDLE, SSR_SHIFT} ssr_link_e;
endpackage

// file: rtl/ssr_status_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.svh"
module ssr_status_core
  import ssr_pkg::*;
#(
  parameter int NCH = 4,
  parameter logic [2:0] DEV_TYPE = 3'h1,  // arbitrary value
  parameter logic [1:0] DEV_FAMILY = 2'h1, // arbitrary value
  parameter logic [2:0] DEV_REV = 3'h0    // arbitrary value
)
(
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial link (frame select low active)
  input wire logic link_clk,
  input wire logic link_sel_n,
  input wire logic link_sdi,
  output logic link_sdo,
  output logic link_sdo_oe,
  // fault sources, asynchronous to ref_clk
  input wire ssr_chan_s [NCH-1:0] chan_fault,
  input wire ssr_dev_s dev_flags,
  input wire logic limp_pin_level,
  input wire logic [NCH-1:0] output_half_battery_compare,
  input wire logic [NCH-1:0] direct_input_level,
  input wire logic [NCH-1:0] input_on_request,
  input wire logic regs_clear_ack,
  // pwm shaping control
  input wire logic [NCH*2-1:0] prescaler_sel,
  input wire logic [NCH*8-1:0] duty_request,
  // pwm shaping results
  output logic [NCH*8-1:0] duty_applied,
  output logic [NCH-1:0] edge_fast,
  output logic [NCH-1:0] edge_match_en,
  output logic [7:0] min_onoff_cycles,
  // status
  output logic [NCH-1:0] channel_quick_summary,
  output logic open_load_summary,
  output logic overload_summary,
  output logic device_status_summary
);

  localparam int SRCW = NCH*5 + 8 + 1 + NCH*3; // width of all synchronised sources
  // minimum on/off times reported in microseconds; both fit in eight bits
  localparam logic [7:0] TMIN_SLOW = 8'(`SSR_TMIN_SLOW_US);
  localparam logic [7:0] TMIN_FAST = 8'(`SSR_TMIN_FAST_US);

  ////////////////////////////////////////////////////////////////
  // ref_clk domain state
  typedef struct packed {
    logic [SRCW-1:0] meta;      // first sync stage
    logic [SRCW-1:0] src;       // synchronised sources
    logic cleared;              // registers-cleared latch
    logic [NCH*8-1:0] duty;     // clamped duty codes
    logic [NCH-1:0] fast;       // edge speed per channel
  } ssr_core_s;

  ssr_core_s core_r, core_nxt;
  logic [SRCW-1:0] raw_src;
  ssr_chan_s [NCH-1:0] cs;
  ssr_dev_s ds;
  logic s_limp;
  logic [NCH-1:0] s_cmp, s_din, s_onreq;
  logic [NCH-1:0] qsum;
  logic ol_sum, ovl_sum, dev_sum;

  assign raw_src = {chan_fault, dev_flags, limp_pin_level,
                    output_half_battery_compare, direct_input_level, input_on_request};
  assign {cs, ds, s_limp, s_cmp, s_din, s_onreq} = core_r.src;

  // summary flags, combinational from synchronised sources
  always_comb
  begin
    ol_sum = 1'b0;
    ovl_sum = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      qsum[i] = |cs[i];
      ol_sum = ol_sum | cs[i].open_load_on_state | cs[i].open_load_off_state;
      ovl_sum = ovl_sum | cs[i].overcurrent | cs[i].overtemp_shutdown;
    end
    dev_sum = core_r.cleared | ds.under_voltage_flag | ds.over_voltage_flag
              | ds.charge_pump_fault | ds.pwm_clock_fail | ds.test_mode_active;
  end

  assign channel_quick_summary = qsum;
  assign open_load_summary = ol_sum;
  assign overload_summary = ovl_sum;
  assign device_status_summary = dev_sum;

  // next state: sync, cleared latch, duty clamp, edge select
  always_comb
  begin
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] d;
    lo = `SSR_DC_MIN4;
    hi = `SSR_DC_MAX4;
    d = 8'h00;
    core_nxt = core_r;
    core_nxt.meta = raw_src;
    core_nxt.src = core_r.meta;
    // set wins over acknowledge
    if (ds.registers_cleared_flag)
      core_nxt.cleared = 1'b1;
    else if (regs_clear_ack)
      core_nxt.cleared = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      // divider 4 allows wider range, 2 and 1 narrower
      if (prescaler_sel[i*2 +: 2] == `SSR_PRS_DIV4)
      begin
        lo = `SSR_DC_MIN4;
        hi = `SSR_DC_MAX4;
      end
      else
      begin
        lo = `SSR_DC_MIN21;
        hi = `SSR_DC_MAX21;
      end
      d = duty_request[i*8 +: 8];
      if (d < lo)
        d = lo;
      else if (d > hi)
        d = hi;
      core_nxt.duty[i*8 +: 8] = d;
      // divider 1 uses fast edges, others slow
      core_nxt.fast[i] = prescaler_sel[i*2+1];
    end
    if (!rst_n)
    begin
      core_nxt = '0;
      core_nxt.cleared = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
    core_r <= core_nxt;

  assign duty_applied = core_r.duty;
  assign edge_fast = core_r.fast;
  // symmetric edges with digital loop enabled on every channel while out of reset, off on all channels in reset
  assign edge_match_en = {NCH{rst_n}};
  // minimum on/off time in microseconds; one figure for the whole block,
  // so any fast channel forces the shorter value (a per-channel figure
  // would cost a port per channel for little gain)
  assign min_onoff_cycles = (|core_r.fast) ? TMIN_FAST : TMIN_SLOW;

  ////////////////////////////////////////////////////////////////
  // status word assembly (ref_clk domain)
  logic [`SSR_WORD_W-1:0] word_sel [16];
  logic [3:0] fm_hi;
  always_comb
  begin
    for (int a = 0; a < 16; a++)
      word_sel[a] = '0;
    fm_hi = {ds.fail_mode_flag, dev_sum, ovl_sum, ol_sum};
    word_sel[`SSR_A_QUICK] = {`SSR_A_QUICK, fm_hi, ds.charge_pump_fault, core_r.cleared,
                              ds.pwm_clock_fail, 1'b0, qsum};
    for (int i = 0; i < NCH; i++)
      word_sel[int'(`SSR_A_CH1) + i] = {4'(int'(`SSR_A_CH1) + i), fm_hi, 1'b0,
        cs[i].overtemp_shutdown, cs[i].overtemp_warning, 2'h0, cs[i].overcurrent,
        cs[i].open_load_on_state, cs[i].open_load_off_state};
    word_sel[`SSR_A_DEV] = {`SSR_A_DEV, fm_hi, 3'h0, ds.test_mode_active, ds.over_voltage_flag,
                            ds.under_voltage_flag, ds.serial_link_fail, s_limp};
    word_sel[`SSR_A_IO] = {`SSR_A_IO, ds.fail_mode_flag, 1'b0, |s_onreq,
                           s_din, 1'b0, s_cmp};
    word_sel[`SSR_A_ID] = {`SSR_A_ID, ds.fail_mode_flag, 3'h0,
                           DEV_REV, DEV_FAMILY, DEV_TYPE};
  end

  ////////////////////////////////////////////////////////////////
  // link domain: frame shifter
  // frame select synchronised into link domain; link clock must keep running between frames
  typedef struct packed {
    logic [1:0] rst_sync;       // reset carried into the link domain
    logic [1:0] sel_sync;       // frame select, two stages
    ssr_link_e st;
    logic [`SSR_CNT_W-1:0] cnt;
    logic [`SSR_WORD_W-1:0] sh_in;
    logic [3:0] addr;           // address of previous frame
    logic [`SSR_WORD_W-1:0] sh_out;
  } ssr_link_s;

  ssr_link_s lk_r, lk_nxt;
  logic [`SSR_WORD_W*16-1:0] snap_bus;
  always_comb
    for (int a = 0; a < 16; a++)
      snap_bus[a*`SSR_WORD_W +: `SSR_WORD_W] = word_sel[a];

  // crossing: status words are quasi-static; loaded only at frame start,
  // when the ref-domain sources have settled through two stages
  always_comb
  begin
    lk_nxt = lk_r;
    lk_nxt.sel_sync = {lk_r.sel_sync[0], ~link_sel_n};
    unique case (lk_r.st)
      SSR_IDLE:
      begin
        if (lk_r.sel_sync[1])
        begin
          // answer selected by previous frame's top nibble
          lk_nxt.sh_out = snap_bus[lk_r.addr*`SSR_WORD_W +: `SSR_WORD_W];
          lk_nxt.cnt = '0;
          lk_nxt.st = SSR_SHIFT;
        end
      end
      SSR_SHIFT:
      begin
        if (!lk_r.sel_sync[1])
        begin
          if (lk_r.cnt == `SSR_FRAME_BITS)
            lk_nxt.addr = lk_r.sh_in[`SSR_ADDR_HI:`SSR_ADDR_LO];
          lk_nxt.st = SSR_IDLE;
        end
        else if (lk_r.cnt != `SSR_FRAME_BITS)
        begin
          lk_nxt.sh_in = {lk_r.sh_in[`SSR_WORD_W-2:0], link_sdi};
          lk_nxt.sh_out = {lk_r.sh_out[`SSR_WORD_W-2:0], 1'b0};
          lk_nxt.cnt = lk_r.cnt + `SSR_CNT_W'(1);
        end
      end
    endcase
    // reset comes from the ref_clk domain and is acted on only after two
    // link_clk stages; a reset shorter than one link_clk period
    // may be missed by the link side, so hold it long enough
    if (!lk_r.rst_sync[1])
    begin
      lk_nxt = '0;
      lk_nxt.addr = `SSR_A_QUICK; // first answer is the quick word
    end
    // the synchroniser itself is never cleared by the reset it carries
    lk_nxt.rst_sync = {lk_r.rst_sync[0], rst_n};
  end

  always_ff @(posedge link_clk)
    lk_r <= lk_nxt;

  assign link_sdo = lk_r.sh_out[`SSR_WORD_W-1];
  assign link_sdo_oe = (lk_r.st == SSR_SHIFT);

  ////////////////////////////////////////////////////////////////
  // checks
  a_quick_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
    qsum[0] == |cs[0]) else $error("quick bit mismatch");
  a_ol_sum: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs[0].open_load_off_state |-> open_load_summary) else $error("open-load summary low");
  a_ovl_sum: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs[0].overtemp_shutdown |-> overload_summary) else $error("overload summary low");
  a_dev_sum: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ds.test_mode_active |-> device_status_summary) else $error("device summary low");
  a_fm_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    word_sel[`SSR_A_IO][11] == ds.fail_mode_flag) else $error("fail-mode bit wrong");
  a_toggle_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
    word_sel[`SSR_A_IO][9] == |s_onreq) else $error("toggle bit wrong");
  a_duty_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && $past(prescaler_sel[1:0]) == `SSR_PRS_DIV4 |-> duty_applied[7:0] >= `SSR_DC_MIN4
    && duty_applied[7:0] <= `SSR_DC_MAX4) else $error("duty out of range");
  a_edge_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 edge_fast[0] == $past(prescaler_sel[1])) else $error("edge speed wrong");
  a_rst_clr: assert property (@(posedge ref_clk)
    !rst_n |=> core_r.cleared && core_r.src == '0) else $error("reset value wrong");
  // a source event sets the cleared latch even when an acknowledge is present
  a_rcf_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ds.registers_cleared_flag |=> core_r.cleared) else $error("cleared latch not set");
  // every channel's edge control stays matched while out of reset
  a_edge_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
    edge_match_en == {NCH{1'b1}}) else $error("edge match off");
  ////////////////////////////////////////////////////////////////
  // link-side checks, reset taken from the link-domain synchroniser
  // select seen high ends the frame at the next link edge
  a_sdo_oe: assert property (@(posedge link_clk) disable iff (!lk_r.rst_sync[1])
    !lk_r.sel_sync[1] |=> !link_sdo_oe) else $error("sdo driven after frame");
  // after sixteen shifts only fill zeros remain in the output shifter
  a_frame_tail: assert property (@(posedge link_clk) disable iff (!lk_r.rst_sync[1])
    lk_r.st == SSR_SHIFT && lk_r.cnt == `SSR_FRAME_BITS |-> !link_sdo) else $error("extra bit shifted");
  // link reset points the next answer at the quick word and releases the line
  a_link_rst: assert property (@(posedge link_clk)
    !lk_r.rst_sync[1] |=> lk_r.addr == `SSR_A_QUICK && !link_sdo_oe) else $error("link reset wrong");
  c_fault: cover property (@(posedge ref_clk) disable iff (!rst_n) overload_summary);
  c_openld: cover property (@(posedge ref_clk) disable iff (!rst_n) open_load_summary);
  c_frame: cover property (@(posedge link_clk) disable iff (!rst_n)
    lk_r.cnt == `SSR_FRAME_BITS);
  // live input word read out over the link
  c_io_read: cover property (@(posedge link_clk) disable iff (!lk_r.rst_sync[1])
    lk_r.st == SSR_SHIFT && lk_r.addr == `SSR_A_IO);
  // acknowledge clearing the cleared latch
  c_clear_ack: cover property (@(posedge ref_clk) disable iff (!rst_n)
    core_r.cleared && regs_clear_ack && !ds.registers_cleared_flag);

endmodule
`default_nettype wire

// file: dv/ssr_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////
// far-side link master: frames of 16 bits, msb first
module ssr_spi_host (
  // link pins toward the block
  output logic link_clk,
  output logic link_sel_n,
  output logic link_sdi,
  // answer from the block
  input wire logic link_sdo,
  input wire logic link_sdo_oe
);
  // free-running link clock; the block syncs select on its edges
  initial
  begin
    link_clk = 1'b0;
    link_sel_n = 1'b1;
    link_sdi = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  //////////////////////////////////////////////////////////////////
  // one frame; the answer belongs to the previous frame's address
  task automatic xfer(input logic [3:0] a, output logic [15:0] rx, output logic ok);
    logic [15:0] tx;
    int n;
    tx = {a, 12'h000}; // address in the top nibble
    rx = 16'h0000;
    n = 0;
    @(posedge link_clk);
    link_sel_n <= 1'b0;
    @(negedge link_clk);
    // bounded wait for the block to take the frame
    while (link_sdo_oe !== 1'b1 && n < 6)
    begin
      @(negedge link_clk);
      n++;
    end
    ok = (n < 6);
    // take each bit at the falling edge, where it stands; the block
    // samples link_sdi at the rising edge in between
    for (int i = 15; i >= 0; i--)
    begin
      rx = {rx[14:0], link_sdo};
      link_sdi = tx[i];
      @(posedge link_clk);
      @(negedge link_clk);
    end
    link_sel_n = 1'b1;
    link_sdi = ~link_sdi; // released line shows no stale bit
    repeat (4) @(posedge link_clk);
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ssr_pkg::*;
  localparam logic [2:0] ID_T = 3'h2; // arbitrary value
  localparam logic [1:0] ID_F = 2'h1; // arbitrary value
  localparam logic [2:0] ID_R = 3'h5; // arbitrary value
  logic ref_clk, rst_n, lclk, sel_n, sdi, sdo, oe, limp, clr, ols, ovl, dss;
  ssr_chan_s [3:0] cf;
  ssr_dev_s df;
  logic [3:0] vcmp, din, onr, qs, efast, emat;
  logic [7:0] psel, tmin;
  logic [31:0] duty, dapp;
  int failures, total_checks;
  //////////////////////////////////////////////////////////////////
  // 100 MHz system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ssr_spi_host host_u (.link_clk(lclk), .link_sel_n(sel_n), .link_sdi(sdi), .link_sdo(sdo), .link_sdo_oe(oe));
  ssr_status_core #(.DEV_TYPE(ID_T), .DEV_FAMILY(ID_F), .DEV_REV(ID_R)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(lclk), .link_sel_n(sel_n), .link_sdi(sdi),
    .link_sdo(sdo), .link_sdo_oe(oe), .chan_fault(cf), .dev_flags(df), .limp_pin_level(limp),
    .output_half_battery_compare(vcmp), .direct_input_level(din), .input_on_request(onr),
    .regs_clear_ack(clr), .prescaler_sel(psel), .duty_request(duty), .duty_applied(dapp),
    .edge_fast(efast), .edge_match_en(emat), .min_onoff_cycles(tmin),
    .channel_quick_summary(qs), .open_load_summary(ols), .overload_summary(ovl),
    .device_status_summary(dss));
  //////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m, input string s);
    total_checks++;
    if ((g & m) !== (e & m))
    begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  // priming frame sets the address, second frame brings the word
  task automatic rd(input logic [3:0] a, output logic [15:0] w);
    logic ok;
    host_u.xfer(a, w, ok);
    host_u.xfer(a, w, ok);
    chk({15'h0, ok}, 16'h0001, 16'h0001, "frame taken");
  endtask
  // two-flop sync needs a few cycles
  task automatic settle;
    repeat (8) @(posedge ref_clk);
  endtask
  //////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    logic [15:0] w;
    chk({9'h0, qs, ols, ovl, dss}, 16'h0001, 16'hffff, "reset flags");
    rd(4'h1, w);
    chk(w, 16'h1440, 16'hffef, "reset quick");
    $display("reset test done");
  endtask
  task automatic t_quick;
    logic [15:0] w;
    @(posedge ref_clk);
    clr <= 1'b1;
    cf <= {5'h00, 5'h01, 5'h08, 5'h10};
    df <= ssr_dev_s'(8'h19);
    settle;
    clr <= 1'b0;
    settle;
    chk({9'h0, qs, ols, ovl, dss}, 16'h003f, 16'hffff, "summaries");
    rd(4'h1, w);
    chk(w, 16'h1fa7, 16'hffef, "quick word");
    $display("quick test done");
  endtask
  task automatic t_chan;
    logic [15:0] w;
    logic [7:0] lo [4] = '{8'h40, 8'h20, 8'h02, 8'h01};
    @(posedge ref_clk);
    df <= '0;
    cf <= {5'h01, 5'h02, 5'h08, 5'h04};
    settle;
    for (int i = 0; i < 4; i++)
    begin
      rd(4'(i + 2), w);
      chk(w, {4'(i + 2), 4'h3, lo[i]}, 16'hff63, "chan word");
    end
    $display("channel test done");
  endtask
  task automatic t_dev;
    logic [15:0] w;
    ssr_dev_s f;
    logic d;
    // cleared flag last: its latch stays set afterwards
    for (int k = 0; k < 8; k++)
    begin
      f = ssr_dev_s'(8'h01 << k);
      d = f.registers_cleared_flag | f.under_voltage_flag | f.over_voltage_flag;
      d = d | f.charge_pump_fault | f.pwm_clock_fail | f.test_mode_active;
      @(posedge ref_clk);
      cf <= '0;
      df <= f;
      limp <= 1'b1;
      settle;
      rd(4'h7, w);
      chk(w, {4'h7, f.fail_mode_flag, d, 5'h00, f.test_mode_active, f.over_voltage_flag,
        f.under_voltage_flag, f.serial_link_fail, 1'b1}, 16'hff1f, "dev word");
      chk({15'h0, dss}, {15'h0, d}, 16'h0001, "dev summary");
    end
    $display("device test done");
  endtask
  task automatic t_io;
    logic [15:0] w;
    logic ok;
    @(posedge ref_clk);
    df <= ssr_dev_s'(8'h01);
    vcmp <= 4'h5;
    din <= 4'ha;
    onr <= 4'h2;
    settle;
    rd(4'h8, w);
    chk(w, 16'h8b45, 16'hfbef, "io word");
    @(posedge ref_clk);
    vcmp <= 4'ha;
    din <= 4'h5;
    onr <= 4'h0;
    settle;
    host_u.xfer(4'h9, w, ok);
    chk(w, 16'h88aa, 16'hfbef, "io live");
    host_u.xfer(4'h0, w, ok);
    chk(w, {8'h98, ID_R, ID_F, ID_T}, 16'hf8ff, "id word");
    host_u.xfer(4'h1, w, ok);
    chk(w, 16'h0000, 16'hffff, "unused word");
    $display("io and id test done");
  endtask
  task automatic t_pwm;
    @(posedge ref_clk);
    psel <= 8'he4;
    duty <= 32'h00ff05fc;
    settle;
    chk(dapp[31:16], 16'h07f7, 16'hffff, "fast clamp");
    chk(dapp[15:0], 16'h07fb, 16'hffff, "slow clamp");
    chk({4'h0, efast, tmin}, 16'h0c4e, 16'hffff, "fast edges");
    chk({12'h0, emat}, 16'h000f, 16'hffff, "edge match");
    @(posedge ref_clk);
    psel <= 8'h00;
    duty <= 32'h03fb0280;
    settle;
    chk(dapp[15:0], 16'h0380, 16'hffff, "div4 low");
    chk(dapp[31:16], 16'h03fb, 16'hffff, "div4 high");
    chk({4'h0, efast, tmin}, 16'h009c, 16'hffff, "slow edges");
    $display("pwm test done");
  endtask
  //////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence; the wait after reset lets the link side leave reset
  initial
  begin
    failures = 0;
    total_checks = 0;
    rst_n = 1'b0;
    clr = 1'b0;
    limp = 1'b0;
    cf = '0;
    df = '0;
    vcmp = 4'h0;
    din = 4'h0;
    onr = 4'h0;
    psel = 8'h00;
    duty = 32'h80808080;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (16) @(posedge ref_clk);
    t_reset;
    t_quick;
    t_chan;
    t_dev;
    t_io;
    t_pwm;
    wrap_up;
  end
  // watchdog, well past the expected run of about 40 us
  initial
  begin
    #300000;
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
